/* File: rtl/edat_timing.sv */
// External data move timing, address sourcing and pointer registers
`timescale 1ns/1ns
`default_nettype none
module edat_timing (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire edat_pkg::edat_sfr_wr_type sfrWr,
  input wire logic [7:0] sfrRdAddr,
  output logic [7:0] sfrRdData,
  input wire logic moveReq,
  input wire edat_pkg::edat_move_cmd_type moveCmd,
  input wire logic [7:0] indirectLow,
  input wire logic [7:0] port2Latch,
  input wire logic ptrIncr,
  input wire logic port4Bit0Pin_n,
  input wire logic [7:0] rdBusIn,
  output logic opFetch,
  output logic cpuHold,
  output logic moveDone,
  output logic [7:0] rdData,
  output edat_pkg::edat_ext_bus_type extBus
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic sfrHit(input edat_pkg::edat_sfr_wr_type wr, input logic [7:0] addr);
    sfrHit = wr.en && (wr.addr == addr);
  endfunction : sfrHit

  // Strobe window for a given access position
  function automatic logic strobeOn(
    input logic active,
    input logic first,
    input logic [2:0] remain,
    input logic zeroStretch,
    input edat_pkg::edat_phase_type ph
  );
    logic startOk;
    logic endOk;
    startOk = !first || (zeroStretch ? (ph != edat_pkg::PH_C1) :
      (ph == edat_pkg::PH_C3 || ph == edat_pkg::PH_C4));
    endOk = (remain != edat_pkg::STRETCH_ZERO) || (zeroStretch ? (ph != edat_pkg::PH_C4) :
      (ph == edat_pkg::PH_C1 || ph == edat_pkg::PH_C2));
    strobeOn = active && startOk && endOk;
  endfunction : strobeOn

  // ----------------------------------------
  // Machine cycle phase
  // ----------------------------------------
  edat_pkg::edat_phase_type phase;
  edat_pkg::edat_phase_type phaseNext;

  edat_phase phaseGen (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .phase(phase)
  );

  assign phaseNext = (phase == edat_pkg::PH_C1) ? edat_pkg::PH_C2 :
                     (phase == edat_pkg::PH_C2) ? edat_pkg::PH_C3 :
                     (phase == edat_pkg::PH_C3) ? edat_pkg::PH_C4 : edat_pkg::PH_C1;

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] dpsQ;
  logic [7:0] clkCtrlQ;
  logic waitEnQ;
  logic [15:0] ptrQ [0:1];
  logic taArmedQ;
  logic [3:0] taCntQ;
  logic [3:0] taCntD;
  logic taArmedD;
  logic [7:0] sfrRdDataQ;
  logic [7:0] sfrRdMux;

  wire ptrIdx = dpsQ[edat_pkg::DPS_SEL_BIT];
  wire [15:0] selPtr = ptrQ[ptrIdx];
  wire [2:0] stretchField = clkCtrlQ[edat_pkg::STRETCH_MSB:edat_pkg::STRETCH_LSB];

  wire wrDps = sfrHit(sfrWr, edat_pkg::SFR_DPS_ADDR);
  wire wrClkCtrl = sfrHit(sfrWr, edat_pkg::SFR_CLKCTRL_ADDR);
  wire wrMemMap = sfrHit(sfrWr, edat_pkg::SFR_MEMMAP_ADDR);
  wire wrTa = sfrHit(sfrWr, edat_pkg::SFR_TA_ADDR);
  wire wrPtrLo = sfrHit(sfrWr, edat_pkg::SFR_PTR_LO_ADDR);
  wire wrPtrHi = sfrHit(sfrWr, edat_pkg::SFR_PTR_HI_ADDR);

  // only the select bit is stored
  wire [7:0] dpsD = {7'h00, sfrWr.data[edat_pkg::DPS_SEL_BIT]};

  // writes and increments act on selected pointer
  wire ptrWe = wrPtrLo || wrPtrHi || ptrIncr;
  wire [15:0] ptrIncVal = selPtr + edat_pkg::PTR_STEP;
  wire [15:0] ptrBase = ptrIncr ? ptrIncVal : selPtr;
  wire [15:0] ptrD = wrPtrLo ? {ptrBase[15:8], sfrWr.data} :
                     wrPtrHi ? {sfrWr.data, ptrBase[7:0]} : ptrBase;

  // ----------------------------------------
  // Timed access gate
  // ----------------------------------------
  wire taKey1 = wrTa && (sfrWr.data == edat_pkg::TA_KEY_FIRST);
  wire taKey2 = wrTa && taArmedQ && (sfrWr.data == edat_pkg::TA_KEY_SECOND);
  wire taOpen = (taCntQ != edat_pkg::TA_CNT_ZERO);
  // wait enable changes only inside the open window
  wire waitEnWe = wrMemMap && taOpen;

  // Any stray write disarms, so the keys must be back to back
  assign taArmedD = taKey1 ? 1'b1 : (sfrWr.en ? 1'b0 : taArmedQ);
  assign taCntD = taKey2 ? edat_pkg::TA_OPEN_CLKS :
                  wrMemMap ? edat_pkg::TA_CNT_ZERO :
                  taOpen ? (taCntQ - edat_pkg::TA_CNT_STEP) : edat_pkg::TA_CNT_ZERO;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dpsQ <= edat_pkg::DPS_RESET;
      clkCtrlQ <= edat_pkg::CLKCTRL_RESET;
      waitEnQ <= edat_pkg::WAIT_EN_RESET;
      taArmedQ <= 1'b0;
      taCntQ <= edat_pkg::TA_CNT_ZERO;
      sfrRdDataQ <= edat_pkg::ZERO_BYTE;
    end else if (clkEn) begin
      if (wrDps) begin
        dpsQ <= dpsD;
      end
      if (wrClkCtrl) begin
        clkCtrlQ <= sfrWr.data;
      end
      if (waitEnWe) begin
        waitEnQ <= sfrWr.data[edat_pkg::WAIT_EN_BIT];
      end
      taArmedQ <= taArmedD;
      taCntQ <= taCntD;
      sfrRdDataQ <= sfrRdMux;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptrQ[0] <= edat_pkg::PTR_RESET;
      ptrQ[1] <= edat_pkg::PTR_RESET;
    end else if (clkEn && ptrWe) begin
      ptrQ[ptrIdx] <= ptrD;
    end
  end

  // Unmapped addresses read zero
  assign sfrRdMux = (sfrRdAddr == edat_pkg::SFR_DPS_ADDR) ? dpsQ :
                    (sfrRdAddr == edat_pkg::SFR_CLKCTRL_ADDR) ? clkCtrlQ :
                    (sfrRdAddr == edat_pkg::SFR_MEMMAP_ADDR) ? {waitEnQ, 7'h00} :
                    (sfrRdAddr == edat_pkg::SFR_PTR_LO_ADDR) ? selPtr[7:0] :
                    (sfrRdAddr == edat_pkg::SFR_PTR_HI_ADDR) ? selPtr[15:8] : edat_pkg::ZERO_BYTE;
  assign sfrRdData = sfrRdDataQ;

  // ----------------------------------------
  // Move sequencer
  // ----------------------------------------
  edat_pkg::edat_move_type moveQ;
  edat_pkg::edat_move_type moveD;
  logic firstQ;
  logic firstD;
  logic [2:0] remainQ;
  logic [2:0] remainD;
  logic zeroStretchQ;
  logic isWriteQ;
  logic moveDoneQ;
  logic [7:0] rdDataQ;
  edat_pkg::edat_ext_bus_type busQ;
  edat_pkg::edat_ext_bus_type busD;

  wire active = (moveQ == edat_pkg::MV_ACCESS);
  // request taken at the last state of its fetch cycle
  wire moveStart = !active && moveReq && (phase == edat_pkg::PH_C4);
  wire cycleEnd = (phase == edat_pkg::PH_C4);
  wire lastCycle = (remainQ == edat_pkg::STRETCH_ZERO);
  // wait pin honoured only while enabled
  // sampled at the second state of the last access cycle
  wire waitSeen = active && lastCycle && waitEnQ && (phase == edat_pkg::PH_C2) && !port4Bit0Pin_n;
  wire moveEnd = active && lastCycle && cycleEnd;

  // indirect register low, port 2 latch high
  wire [15:0] startAddr = moveCmd.indirect ? {port2Latch, indirectLow} : selPtr;

  always_comb begin
    case (moveQ)
      edat_pkg::MV_IDLE: moveD = moveStart ? edat_pkg::MV_ACCESS : edat_pkg::MV_IDLE;
      edat_pkg::MV_ACCESS: moveD = moveEnd ? edat_pkg::MV_IDLE : edat_pkg::MV_ACCESS;
      default: moveD = edat_pkg::MV_IDLE;
    endcase
  end

  // stretch n gives n access cycles beyond the first
  // each wait adds one more access cycle
  assign remainD = moveStart ? stretchField :
                   waitSeen ? edat_pkg::REMAIN_ONE :
                   (active && cycleEnd && !lastCycle) ? (remainQ - edat_pkg::REMAIN_ONE) : remainQ;
  assign firstD = moveStart ? 1'b1 : ((active && cycleEnd) ? 1'b0 : firstQ);

  wire zeroStretchD = moveStart ? (stretchField == edat_pkg::STRETCH_ZERO) : zeroStretchQ;
  wire activeD = (moveD == edat_pkg::MV_ACCESS);
  // strobe spans 2 clocks at zero, else 4 per stretch step
  wire strobeNow = strobeOn(active, firstQ, remainQ, zeroStretchQ, phase);
  wire strobeNext = strobeOn(activeD, firstD, remainD, zeroStretchD, phaseNext);
  wire writeD = moveStart ? moveCmd.write : isWriteQ;
  wire rdCapture = strobeNow && !strobeNext && !isWriteQ;

  always_comb begin
    busD = busQ;
    if (moveStart) begin
      busD.addr = startAddr;
      busD.wrData = moveCmd.wrData;
    end
    busD.dataOe = activeD && writeD;
    busD.rdStrobe_n = !(strobeNext && !writeD);
    busD.wrStrobe_n = !(strobeNext && writeD);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      moveQ <= edat_pkg::MV_IDLE;
      firstQ <= 1'b0;
      remainQ <= edat_pkg::STRETCH_ZERO;
      zeroStretchQ <= 1'b0;
      isWriteQ <= 1'b0;
    end else if (clkEn) begin
      moveQ <= moveD;
      firstQ <= firstD;
      remainQ <= remainD;
      zeroStretchQ <= zeroStretchD;
      isWriteQ <= writeD;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busQ <= '{
        addr: edat_pkg::PTR_RESET,
        wrData: edat_pkg::ZERO_BYTE,
        dataOe: 1'b0,
        rdStrobe_n: 1'b1,
        wrStrobe_n: 1'b1
      };
      moveDoneQ <= 1'b0;
    end else if (clkEn) begin
      busQ <= busD;
      moveDoneQ <= moveEnd;
    end
  end

  // ----------------------------------------
  // Read data capture
  // ----------------------------------------
  // taken at last strobe clock
  // Sampled while strobe still low, so a slow device has the whole width
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdDataQ <= edat_pkg::ZERO_BYTE;
    end else if (clkEn && rdCapture) begin
      rdDataQ <= rdBusIn;
    end
  end

  // ----------------------------------------
  // Core side
  // ----------------------------------------
  // one fetch slot at the first state of each free cycle
  assign opFetch = (phase == edat_pkg::PH_C1) && !active;
  // core held only while a move is in its access cycles
  assign cpuHold = active;
  assign moveDone = moveDoneQ;
  assign rdData = rdDataQ;
  assign extBus = busQ;

endmodule : edat_timing
`default_nettype wire

/* File: rtl/edat_pkg.sv */
// Constants, layouts and types for external data access timing
package edat_pkg;

  // ----------------------------------------
  // Special function register map
  // ----------------------------------------
  localparam logic [7:0] SFR_PTR_LO_ADDR = 8'h82;
  localparam logic [7:0] SFR_PTR_HI_ADDR = 8'h83;
  localparam logic [7:0] SFR_DPS_ADDR = 8'h86;
  localparam logic [7:0] SFR_CLKCTRL_ADDR = 8'h8f;
  localparam logic [7:0] SFR_MEMMAP_ADDR = 8'h9c;
  localparam logic [7:0] SFR_TA_ADDR = 8'hc7;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int DPS_SEL_BIT = 0;
  localparam int STRETCH_LSB = 0;
  localparam int STRETCH_MSB = 2;
  localparam int WAIT_EN_BIT = 7;
  localparam logic [7:0] DPS_RESET = 8'h00;
  localparam logic [7:0] CLKCTRL_RESET = 8'h01;
  localparam logic WAIT_EN_RESET = 1'b0;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [2:0] STRETCH_ZERO = 3'h0;
  localparam logic [2:0] REMAIN_ONE = 3'h1;
  localparam logic [15:0] PTR_STEP = 16'h0001;

  // ----------------------------------------
  // Timed access protection
  // ----------------------------------------
  localparam logic [7:0] TA_KEY_FIRST = 8'haa;
  localparam logic [7:0] TA_KEY_SECOND = 8'h55;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TA_OPEN_NS = 40;
  localparam int TA_OPEN_CLKS_INT = (TA_OPEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] TA_OPEN_CLKS = 4'(TA_OPEN_CLKS_INT);
  localparam logic [3:0] TA_CNT_ZERO = 4'h0;
  localparam logic [3:0] TA_CNT_STEP = 4'h1;

  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [3:0] {
    PH_C1 = 4'b0001,
    PH_C2 = 4'b0010,
    PH_C3 = 4'b0100,
    PH_C4 = 4'b1000
  } edat_phase_type;

  typedef enum logic [1:0] {
    MV_IDLE = 2'b01,
    MV_ACCESS = 2'b10
  } edat_move_type;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } edat_sfr_wr_type;

  typedef struct packed {
    logic write;
    logic indirect;
    logic [7:0] wrData;
  } edat_move_cmd_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wrData;
    logic dataOe;
    logic rdStrobe_n;
    logic wrStrobe_n;
  } edat_ext_bus_type;

endpackage : edat_pkg

/* File: rtl/edat_phase.sv */
// Four-state machine cycle sequencer
`timescale 1ns/1ns
`default_nettype none
module edat_phase (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  output var edat_pkg::edat_phase_type phase
);

  edat_pkg::edat_phase_type phaseQ;
  edat_pkg::edat_phase_type phaseD;

  // ----------------------------------------
  // State order
  // ----------------------------------------
  // fixed state order
  always_comb begin
    case (phaseQ)
      edat_pkg::PH_C1: phaseD = edat_pkg::PH_C2;
      edat_pkg::PH_C2: phaseD = edat_pkg::PH_C3;
      edat_pkg::PH_C3: phaseD = edat_pkg::PH_C4;
      edat_pkg::PH_C4: phaseD = edat_pkg::PH_C1;
      default: phaseD = edat_pkg::PH_C1;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phaseQ <= edat_pkg::PH_C1;
    end else if (clkEn) begin
      phaseQ <= phaseD;
    end
  end

  assign phase = phaseQ;

endmodule : edat_phase
`default_nettype wire

/* File: tb/edat_timing_properties.sv */
// Port checks for the external data move timing block
`timescale 1ns/1ns
`default_nettype none
module edat_timing_properties (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire edat_pkg::edat_sfr_wr_type sfrWr,
  input wire logic [7:0] sfrRdAddr,
  input wire logic [7:0] sfrRdData,
  input wire logic moveReq,
  input wire edat_pkg::edat_move_cmd_type moveCmd,
  input wire logic [7:0] indirectLow,
  input wire logic [7:0] port2Latch,
  input wire logic ptrIncr,
  input wire logic port4Bit0Pin_n,
  input wire logic opFetch,
  input wire logic cpuHold,
  input wire logic moveDone,
  input wire logic [7:0] rdData,
  input wire edat_pkg::edat_ext_bus_type extBus
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Strobe width counter
  // ----------------------------------------
  logic strobeLow;
  logic [7:0] lowCnt_q;
  logic waitSeen_q;
  assign strobeLow = !extBus.rdStrobe_n || !extBus.wrStrobe_n;
  // Eight bits only: long wait tests would wrap it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lowCnt_q <= 8'h00;
      waitSeen_q <= 1'b0;
    end else begin
      lowCnt_q <= strobeLow ? lowCnt_q + 8'h01 : 8'h00;
      waitSeen_q <= strobeLow && (waitSeen_q || !port4Bit0Pin_n);
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_fetch_spacing: assert property (opFetch |=> !opFetch [*3])
    else $error("op-code fetch closer than one machine cycle");
  chk_strobe_single: assert property (!(!extBus.rdStrobe_n && !extBus.wrStrobe_n))
    else $error("read and write strobes low together");
  chk_strobe_min: assert property ($rose(strobeLow) |-> strobeLow [*2])
    else $error("strobe shorter than two clocks");
  chk_strobe_max: assert property (lowCnt_q > 8'd28 |-> waitSeen_q)
    else $error("strobe longer than 28 clocks without wait");
  chk_width_steps: assert property (strobeLow == 1'b0 && lowCnt_q != 8'h00 && !waitSeen_q
    |-> lowCnt_q == 8'd2 || (lowCnt_q[1:0] == 2'b00 && lowCnt_q <= 8'd28))
    else $error("strobe width not a stretch step");
  chk_addr_steady: assert property (strobeLow && $past(strobeLow) |-> $stable(extBus.addr))
    else $error("address moved during strobe");
  chk_write_drive: assert property (!extBus.wrStrobe_n |-> extBus.dataOe)
    else $error("write strobe without driven data");
  chk_read_float: assert property (!extBus.rdStrobe_n |-> !extBus.dataOe)
    else $error("data driven during read strobe");
  chk_no_fetch: assert property (strobeLow |-> !opFetch)
    else $error("op-code fetch during access");
  chk_select_zero: assert property (sfrRdAddr == edat_pkg::SFR_DPS_ADDR
    && $past(sfrRdAddr) == edat_pkg::SFR_DPS_ADDR |-> sfrRdData[7:1] == 7'h00)
    else $error("pointer select upper bits not zero");
  cover property ($rose(extBus.wrStrobe_n));
  cover property (lowCnt_q == 8'd28);
  cover property (waitSeen_q && !strobeLow);
endmodule : edat_timing_properties

bind edat_timing edat_timing_properties chk_u (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
  .sfrWr(sfrWr), .sfrRdAddr(sfrRdAddr), .sfrRdData(sfrRdData), .moveReq(moveReq), .moveCmd(moveCmd),
  .indirectLow(indirectLow), .port2Latch(port2Latch), .ptrIncr(ptrIncr), .port4Bit0Pin_n(port4Bit0Pin_n),
  .opFetch(opFetch), .cpuHold(cpuHold), .moveDone(moveDone), .rdData(rdData), .extBus(extBus));
`default_nettype wire

/* File: tb/edat_ext_mem.sv */
// External data memory model with a wait request output
`timescale 1ns/1ns
`default_nettype none
module edat_ext_mem (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire edat_pkg::edat_ext_bus_type extBus,
  input wire logic [7:0] waitClks,
  output logic port4Bit0Pin_n,
  output logic [15:0] lastAddr,
  output logic [7:0] lastData,
  output logic [7:0] rdBus
);
  logic strobeLow;
  logic [7:0] lowCnt_q;
  logic [7:0] mem_q [0:15];
  assign strobeLow = !extBus.rdStrobe_n || !extBus.wrStrobe_n;
  // Released bus shows the inverse, so a late sample is caught
  assign rdBus = extBus.rdStrobe_n ? ~mem_q[extBus.addr[3:0]] : mem_q[extBus.addr[3:0]];
  // active low request, held while busy
  assign port4Bit0Pin_n = !(strobeLow && lowCnt_q < waitClks);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lowCnt_q <= 8'h00;
      lastAddr <= 16'h0000;
      lastData <= 8'h00;
      for (int i = 0; i < 16; i++) begin
        mem_q[i] <= 8'h00;
      end
    end else begin
      lowCnt_q <= strobeLow ? lowCnt_q + 8'h01 : 8'h00;
      if (strobeLow && lowCnt_q == 8'h00) begin
        lastAddr <= extBus.addr;
      end
      if (!extBus.wrStrobe_n && extBus.dataOe) begin
        lastData <= extBus.wrData;
        mem_q[extBus.addr[3:0]] <= extBus.wrData;
      end
    end
  end
endmodule : edat_ext_mem
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the external data move timing block
`timescale 1ns/1ns
`default_nettype none
`define CHECK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module tb_top;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  edat_pkg::edat_sfr_wr_type sfrWr = '0;
  logic [7:0] sfrRdAddr = 8'h00;
  logic [7:0] sfrRdData;
  logic moveReq = 1'b0;
  edat_pkg::edat_move_cmd_type moveCmd = '0;
  logic [7:0] indirectLow = 8'h00;
  logic [7:0] port2Latch = 8'h00;
  logic ptrIncr = 1'b0;
  logic port4Bit0Pin_n;
  logic opFetch;
  logic cpuHold;
  logic moveDone;
  logic [7:0] rdData;
  edat_pkg::edat_ext_bus_type extBus;
  logic [7:0] waitClks = 8'h00;
  logic [15:0] lastAddr;
  logic [7:0] lastData;
  logic [7:0] rdBus;
  logic [7:0] rd;
  int n_errors = 0;
  int n_tests = 0;
  int w;
  always #5 core_clk = ~core_clk;
  edat_timing dut_u (.core_clk(core_clk), .rst_n(rst_n), .clkEn(1'b1), .sfrWr(sfrWr), .sfrRdAddr(sfrRdAddr),
    .sfrRdData(sfrRdData), .moveReq(moveReq), .moveCmd(moveCmd), .indirectLow(indirectLow),
    .port2Latch(port2Latch), .ptrIncr(ptrIncr), .port4Bit0Pin_n(port4Bit0Pin_n), .opFetch(opFetch),
    .rdBusIn(rdBus), .cpuHold(cpuHold), .moveDone(moveDone), .rdData(rdData), .extBus(extBus));
  edat_ext_mem mem_u (.core_clk(core_clk), .rst_n(rst_n), .extBus(extBus), .waitClks(waitClks),
    .port4Bit0Pin_n(port4Bit0Pin_n), .lastAddr(lastAddr), .lastData(lastData), .rdBus(rdBus));
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfrWr <= '{en: 1'b1, addr: a, data: d};
    @(posedge core_clk);
    sfrWr <= '0;
  endtask : sfr_write
  task automatic sfr_read(input logic [7:0] a);
    @(posedge core_clk);
    sfrRdAddr <= a;
    repeat (2) @(posedge core_clk);
    #1 rd = sfrRdData;
  endtask : sfr_read
  // Bounded wait on completion; strobe low clocks counted meanwhile
  task automatic do_move(input logic wr, input logic ind, input logic [7:0] d);
    int k;
    w = 0;
    @(posedge core_clk);
    moveReq <= 1'b1;
    moveCmd <= '{write: wr, indirect: ind, wrData: d};
    for (k = 0; k < 400; k++) begin
      @(posedge core_clk);
      #1;
      if (extBus.rdStrobe_n === 1'b0 || extBus.wrStrobe_n === 1'b0) w++;
      if (moveDone === 1'b1) break;
    end
    @(posedge core_clk);
    moveReq <= 1'b0;
    if (k == 400) begin
      n_errors++;
      print_verdict();
    end
  endtask : do_move
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    sfr_read(edat_pkg::SFR_CLKCTRL_ADDR);
    `CHECK("stretch reset", 3'h1, rd[2:0])
    sfr_read(edat_pkg::SFR_DPS_ADDR);
    `CHECK("select reset", 8'h00, rd)
    do_move(1'b0, 1'b0, 8'h00);
    `CHECK("default width", 4, w)
    sfr_write(edat_pkg::SFR_DPS_ADDR, 8'hff);
    sfr_read(edat_pkg::SFR_DPS_ADDR);
    `CHECK("select readback", 8'h01, rd)
  endtask : t_reset
  task automatic t_addr();
    sfr_write(edat_pkg::SFR_PTR_LO_ADDR, 8'hcd);
    sfr_write(edat_pkg::SFR_PTR_HI_ADDR, 8'hab);
    sfr_write(edat_pkg::SFR_DPS_ADDR, 8'h00);
    sfr_write(edat_pkg::SFR_PTR_LO_ADDR, 8'h34);
    sfr_write(edat_pkg::SFR_PTR_HI_ADDR, 8'h12);
    do_move(1'b1, 1'b0, 8'h5a);
    `CHECK("primary addr", 16'h1234, lastAddr)
    `CHECK("write data", 8'h5a, lastData)
    sfr_write(edat_pkg::SFR_DPS_ADDR, 8'h01);
    @(posedge core_clk);
    ptrIncr <= 1'b1;
    @(posedge core_clk);
    ptrIncr <= 1'b0;
    do_move(1'b0, 1'b0, 8'h00);
    `CHECK("secondary addr", 16'habce, lastAddr)
    port2Latch <= 8'h9e;
    indirectLow <= 8'h3c;
    do_move(1'b1, 1'b1, 8'ha5);
    `CHECK("indirect addr", 16'h9e3c, lastAddr)
    `CHECK("indirect data", 8'ha5, lastData)
    do_move(1'b0, 1'b1, 8'h00);
    `CHECK("indirect read", 8'ha5, rdData)
  endtask : t_addr
  task automatic t_stretch();
    for (int s = 0; s < 8; s++) begin
      sfr_write(edat_pkg::SFR_CLKCTRL_ADDR, 8'(s));
      do_move(s[0], 1'b0, 8'h11);
      `CHECK("strobe width", (s == 0) ? 2 : 4 * s, w)
    end
  endtask : t_stretch
  task automatic t_wait();
    sfr_write(edat_pkg::SFR_CLKCTRL_ADDR, 8'h01);
    waitClks <= 8'd12;
    sfr_write(edat_pkg::SFR_MEMMAP_ADDR, 8'h80);
    sfr_read(edat_pkg::SFR_MEMMAP_ADDR);
    `CHECK("unkeyed enable", 1'b0, rd[7])
    do_move(1'b0, 1'b0, 8'h00);
    `CHECK("wait ignored", 4, w)
    `CHECK("read data", 8'h11, rdData)
    sfr_write(edat_pkg::SFR_TA_ADDR, edat_pkg::TA_KEY_FIRST);
    sfr_write(edat_pkg::SFR_TA_ADDR, edat_pkg::TA_KEY_SECOND);
    sfr_write(edat_pkg::SFR_MEMMAP_ADDR, 8'h80);
    sfr_read(edat_pkg::SFR_MEMMAP_ADDR);
    `CHECK("keyed enable", 1'b1, rd[7])
    do_move(1'b1, 1'b0, 8'h3c);
    `CHECK("wait stretched", 16, w)
    waitClks <= 8'd0;
    do_move(1'b0, 1'b0, 8'h00);
    `CHECK("wait released", 4, w)
    `CHECK("waited data", 8'h3c, rdData)
  endtask : t_wait
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_addr();
    t_stretch();
    t_wait();
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
